// file: hw/usb_port_fault_manager.sv
// Fault supervision, recovery and shield gate control with an AHB-Lite register slave
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "fault_map.svh"
module usb_port_fault_manager #(
    parameter int CYC_THERM = `CYC_US(`T_THERM_US),
    parameter int CYC_INUV = `CYC_US(`T_INUV_US),
    parameter int CYC_ILIM = `CYC_US(`T_ILIM_US),
    parameter int CYC_OCP = `CYC_US(`T_OCP_US),
    parameter int CYC_OV_CL = `CYC_US(`T_OV_CL_US),
    parameter int CYC_BUSUV = `CYC_US(`T_BUSUV_US),
    parameter int CYC_CONN_OCL = `CYC_US(`T_CONN_OCL_US),
    parameter int CYC_CONN_STG = `CYC_US(`T_CONN_STG_US + `T_STG_DB_US),
    parameter int CYC_STG_DB = `CYC_US(`T_STG_DB_US),
    parameter int CYC_RUNAWAY = `CYC_US(`T_RUNAWAY_US),
    parameter int CYC_MS = `CYC_US(`T_MS_US)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire fault_pkg::cmp_in_t cmp_in,
    input wire fault_pkg::port_in_t port_in,
    output fault_pkg::ctl_out_t ctl_out,
    output logic shield_gate_out,
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe_n
);
    import fault_pkg::*;

    localparam int NCH = 17;
    localparam int CYC_CONN_OCH = `CYC_US(`T_CONN_OCH_US);
    localparam int CYC_SHLD_THR = `CYC_US(`T_SHLD_THR_US);
    localparam int CYC_SHLD_SLOPE = `CYC_US(`T_SHLD_SLOPE_US);

    logic [31:0] ctrl_r;
    logic [31:0] mask_r;
    logic [17:0] flags_r;
    logic [17:0] flags_nxt;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [22:0] cnt_r [NCH];
    logic [22:0] lim [NCH];
    logic [NCH-1:0] cond;
    logic [NCH-1:0] fire;
    logic [17:0] ms_div_r;
    logic ms_tick_r;
    logic a_active_r;
    logic [7:0] conn_off_ms_r;
    logic [1:0] b_cnt_r;
    logic hi_load_r;
    logic bc_sup_r;
    logic pd_sup_r;
    logic shield_trip_r;
    logic [17:0] shield_hold_r;
    logic reg_mode;
    logic current_limit_mode_en;
    logic bus_on;
    logic conn_on;
    logic suppress;
    logic attach;
    logic ev_a;
    logic ev_b;
    logic ev_d;
    logic b_third;
    logic a_cond;
    logic fault_any;
    logic alert_ev;
    logic gate_ok;

    function automatic logic is_term(input term_t t);
        is_term = (t == TERM_RA) || (t == TERM_RD);
    endfunction

    function automatic logic [22:0] cyc(input int c);
        cyc = 23'(c);
    endfunction

    assign current_limit_mode_en = ctrl_r[`CTRL_CURRENT_LIMIT_MODE_EN];
    assign bus_on = port_in.bus_sourced;
    assign conn_on = ctl_out.conn_sw_close;
    assign reg_mode = flags_r[`F_REG_MODE];
    assign attach = is_term(port_in.conn_config_line_a) || is_term(port_in.conn_config_line_b);
    assign suppress = hi_load_r || bc_sup_r || pd_sup_r;

    // Conditions; the bus and connector ones already gated by what is being sourced
    always_comb begin
        cond[0] = cmp_in.over_temp;
        cond[1] = cmp_in.input_uv_flag;
        cond[2] = bus_on && cmp_in.bus_ilim && !current_limit_mode_en;
        cond[3] = bus_on && cmp_in.bus_ocp;
        cond[4] = bus_on && cmp_in.bus_ov && !cmp_in.bus_softstart
            && !(cmp_in.bus_transition && !current_limit_mode_en);
        cond[5] = bus_on && cmp_in.bus_uv && !reg_mode && !cmp_in.bus_softstart;
        cond[6] = conn_on && cmp_in.conn_oc_lo;
        cond[7] = conn_on && cmp_in.conn_oc_hi;
        cond[8] = ctrl_r[`CTRL_CONN_REQ] && !conn_on && cmp_in.cc_below_stg;
        cond[9] = cmp_in.shield_thr && !suppress;
        cond[10] = cmp_in.shield_slope && !suppress;
        cond[11] = bus_on && cmp_in.bus_runaway && !current_limit_mode_en;
        cond[12] = cmp_in.cc_a_ov || cmp_in.cc_b_ov;
        cond[13] = cmp_in.dp_ov || cmp_in.dm_ov;
        cond[14] = cmp_in.usb_ov;
        cond[15] = cmp_in.usb_uv;
        cond[16] = bus_on && (current_limit_mode_en ? cmp_in.bus_below_2v85 : cmp_in.bus_below_2v0);
    end

    always_comb begin
        lim[0] = cyc(CYC_THERM);
        lim[1] = cyc(CYC_INUV);
        lim[2] = cyc(CYC_ILIM);
        lim[3] = current_limit_mode_en ? 23'h000001 : cyc(CYC_OCP);
        lim[4] = current_limit_mode_en ? cyc(CYC_OV_CL) : 23'h000001;
        lim[5] = cyc(CYC_BUSUV);
        lim[6] = cyc(CYC_CONN_OCL);
        lim[7] = cyc(CYC_CONN_OCH);
        lim[8] = cyc(CYC_CONN_STG);
        lim[9] = cyc(CYC_SHLD_THR);
        lim[10] = cyc(CYC_SHLD_SLOPE);
        lim[11] = cyc(CYC_RUNAWAY);
        for (int i = 12; i < NCH; i++) begin
            lim[i] = 23'h000001;
        end
    end

    // One pulse when a condition has held for its full time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCH; i++) begin
                cnt_r[i] <= 23'h000000;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!cond[i]) begin
                    cnt_r[i] <= 23'h000000;
                end else if (cnt_r[i] != lim[i]) begin
                    cnt_r[i] <= cnt_r[i] + 23'h000001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fire[i] = cond[i] && (cnt_r[i] == lim[i] - 23'h000001);
        end
    end

    // Supply undervoltage is alert only, so it stays out of the action A sum
    assign ev_a = |{fire[4:0], fire[14:9], fire[16]};
    assign ev_b = fire[6] || fire[7];
    assign ev_d = fire[8];
    assign b_third = ev_b && (b_cnt_r == 2'b10);
    assign a_cond = |{cond[4:0], cond[14:9], cond[16]};
    assign fault_any = a_cond || cond[6] || cond[7] || cond[8];
    assign alert_ev = ev_a || fire[15] || fire[5] || b_third || ev_d;

    always_comb begin
        flags_nxt = flags_r;
        if (wr_pend_r && wr_addr_r == `REG_FLAGS) begin
            flags_nxt = flags_r & ~hwdata[17:0];
        end
        if (fire[0]) flags_nxt[`F_THERM] = 1'b1;
        if (fire[1]) flags_nxt[`F_INPUT_UV_FLAG] = 1'b1;
        if (fire[2]) flags_nxt[`F_ILIM] = 1'b1;
        if (fire[3]) flags_nxt[`F_BUS_OC] = 1'b1;
        if (fire[4]) flags_nxt[`F_BUS_OV] = 1'b1;
        if (fire[5]) flags_nxt[`F_BUS_UV] = 1'b1;
        if (b_third) flags_nxt[`F_CONN_OC] = 1'b1;
        if (b_third && fire[6]) flags_nxt[`F_CONN_OCL] = 1'b1;
        if (fire[9] || fire[10]) flags_nxt[`F_SHIELD] = 1'b1;
        if (fire[11]) flags_nxt[`F_RUNAWAY] = 1'b1;
        if (fire[12]) flags_nxt[`F_CC_OV] = 1'b1;
        if (fire[13]) flags_nxt[`F_DATA_LINE_OV_FLAG] = 1'b1;
        if (fire[14]) flags_nxt[`F_USB_OV] = 1'b1;
        if (fire[15]) flags_nxt[`F_USB_UV] = 1'b1;
        if (fire[16]) flags_nxt[`F_BUS_STG] = 1'b1;
        // Regulation is a live state, not a latched event
        flags_nxt[`F_REG_MODE] = bus_on && current_limit_mode_en && cmp_in.bus_ilim;
        if (alert_ev && !ev_d) flags_nxt[`F_SUMMARY] = 1'b1;
        if (alert_ev && mask_r[`MASK_SUMMARY]) flags_nxt[`F_VENDOR] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= 18'h00000;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_div_r <= 18'h00000;
            ms_tick_r <= 1'b0;
        end else begin
            ms_tick_r <= (ms_div_r == 18'(CYC_MS - 1));
            ms_div_r <= (ms_div_r == 18'(CYC_MS - 1)) ? 18'h00000 : ms_div_r + 18'h00001;
        end
    end

    // Retry timer stands still while any fault other than bus or supply undervoltage is still seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conn_off_ms_r <= 8'h00;
        end else if (ev_a || b_third) begin
            conn_off_ms_r <= ctrl_r[`CTRL_RETRY_LSB +: 8];
        end else if (ev_d) begin
            conn_off_ms_r <= `STG_RETRY_MS;
        end else if (ev_b) begin
            conn_off_ms_r <= 8'h01;
        end else if (ms_tick_r && !fault_any && conn_off_ms_r != 8'h00) begin
            conn_off_ms_r <= conn_off_ms_r - 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_active_r <= 1'b0;
        end else if (ev_a) begin
            a_active_r <= 1'b1;
        end else if (!a_cond && conn_off_ms_r == 8'h00) begin
            a_active_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_cnt_r <= 2'b00;
        end else if (!ctrl_r[`CTRL_CONN_REQ] || b_third) begin
            b_cnt_r <= 2'b00;
        end else if (ev_b) begin
            b_cnt_r <= b_cnt_r + 2'b01;
        end
    end

    // Suppression latches for shield detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_load_r <= 1'b0;
            bc_sup_r <= 1'b0;
            pd_sup_r <= 1'b0;
        end else begin
            if (cmp_in.load_above_hi) hi_load_r <= 1'b1;
            else if (cmp_in.load_below_lo) hi_load_r <= 1'b0;
            if (cmp_in.bc_started && ctrl_r[`CTRL_AUTO_CHG]) bc_sup_r <= 1'b1;
            else if (!attach) bc_sup_r <= 1'b0;
            if (!bus_on) pd_sup_r <= 1'b0;
            else if (cmp_in.pd_sent) pd_sup_r <= 1'b1;
        end
    end

    // Shield trip holds until the sense has been quiet for 1ms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shield_trip_r <= 1'b0;
            shield_hold_r <= 18'h00000;
        end else if (fire[9] || fire[10] || (shield_trip_r && (cond[9] || cond[10]))) begin
            shield_trip_r <= 1'b1;
            shield_hold_r <= 18'(CYC_MS);
        end else if (shield_hold_r != 18'h00000) begin
            shield_hold_r <= shield_hold_r - 18'h00001;
        end else begin
            shield_trip_r <= 1'b0;
        end
    end

    assign gate_ok = !port_in.supply_lockout && port_in.high_voltage_enable
        && (bus_on || conn_on || attach);

    // Actions touch the power path, the data and CC switches and the BC reset; pull-ups and the port controller are untouched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_out <= '0;
            shield_gate_out <= 1'b0;
        end else begin
            shield_gate_out <= gate_ok && !shield_trip_r && !flags_nxt[`F_SHIELD];
            ctl_out.conv_en <= ctrl_r[`CTRL_BUS_EN] && !ev_a;
            ctl_out.conv_discharge <= a_active_r || ev_a;
            ctl_out.data_sw_close <= !(a_active_r || ev_a);
            ctl_out.cc_sw_close <= !(a_active_r || ev_a);
            ctl_out.cc_discharge <= a_active_r || ev_a;
            ctl_out.conn_sw_close <= ctrl_r[`CTRL_CONN_REQ] && !(ev_a || ev_b || ev_d)
                && conn_off_ms_r == 8'h00 && !a_active_r && !cond[8];
            ctl_out.bc_reset <= ev_a;
            ctl_out.cur_regulate <= flags_nxt[`F_REG_MODE];
        end
    end

    // Alert pin pulls low only for a masked-in pending alert
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alert_out <= 1'b0;
            alert_oe_n <= 1'b1;
        end else begin
            alert_out <= 1'b0;
            alert_oe_n <= !(flags_nxt[`F_VENDOR] && mask_r[`MASK_VENDOR]);
        end
    end

    // Bus slave: zero wait, writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= hready && hsel && htrans[1] && hwrite;
            wr_addr_r <= haddr[7:0];
            hrdata <= 32'h0000_0000;
            if (hready && hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h000000) begin
                case (haddr[7:0])
                    `REG_CTRL: hrdata <= ctrl_r;
                    `REG_FLAGS: hrdata <= {14'h0000, flags_r};
                    `REG_MASK: hrdata <= mask_r;
                    `REG_STATUS: hrdata <= {24'h000000, b_cnt_r, alert_in, suppress,
                        shield_trip_r, a_active_r, conn_on, shield_gate_out};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `CTRL_RESET;
            mask_r <= `MASK_RESET;
        end else begin
            if (wr_pend_r && wr_addr_r == `REG_CTRL) begin
                ctrl_r <= {16'h0000, hwdata[15:8], 4'h0, hwdata[3:0]};
            end
            if (ev_a) begin
                ctrl_r[`CTRL_BUS_EN] <= 1'b0;
            end
            if (wr_pend_r && wr_addr_r == `REG_MASK) begin
                mask_r <= {30'h00000000, hwdata[1:0]};
            end
        end
    end

    a_gate_lockout: assert property (@(posedge hclk) disable iff (!hresetn)
        port_in.supply_lockout |=> !shield_gate_out)
        else $error("gate high under supply lockout");
    a_shield_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(cond[9] || cond[10]) && shield_trip_r |=> !shield_gate_out [*8])
        else $error("gate released too early after shield fault");
    a_alert_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        !mask_r[`MASK_VENDOR] |=> alert_oe_n)
        else $error("alert driven while masked");
    a_bus_never_auto: assert property (@(posedge hclk) disable iff (!hresetn)
        ev_a |=> !ctrl_r[`CTRL_BUS_EN] && !ctl_out.conv_en)
        else $error("bus not disabled by action A");
    a_ov_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
        cmp_in.usb_ov |=> flags_r[`F_USB_OV] && !ctl_out.data_sw_close)
        else $error("supply overvoltage not acted on at once");
    a_uv_reg_silent: assert property (@(posedge hclk) disable iff (!hresetn)
        reg_mode && !flags_r[`F_BUS_UV] |=> !flags_r[`F_BUS_UV])
        else $error("bus undervoltage reported while regulating");
    a_retry_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
        fault_any && !(ev_a || ev_b || ev_d) |=> conn_off_ms_r == $past(conn_off_ms_r))
        else $error("retry timer ran during a fault");
    a_debounce_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        !cond[0] |=> cnt_r[0] == 23'h000000)
        else $error("debounce did not restart");
    a_third_alert: assert property (@(posedge hclk) disable iff (!hresetn)
        ev_b && b_cnt_r != 2'b10 |=> !flags_r[`F_CONN_OC] || $past(flags_r[`F_CONN_OC]))
        else $error("connector fault reported before the third");
endmodule

// file: shared/fault_map.svh
// Offsets, field positions, reset values and timing figures of the fault manager
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH
`define CLK_PERIOD_NS 4
`define CYC_US(t) ((((t) * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_THERM_US 100
`define T_INUV_US 100
`define T_ILIM_US 16000
`define T_OCP_US 50
`define T_OV_CL_US 250
`define T_BUSUV_US 16000
`define T_CONN_OCL_US 400
`define T_CONN_OCH_US 5
`define T_CONN_STG_US 8000
`define T_STG_DB_US 30
`define T_SHLD_THR_US 5
`define T_SHLD_SLOPE_US 2
`define T_RUNAWAY_US 50
`define T_MS_US 1000
`define STG_RETRY_MS 8'h10
`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_MASK 8'h08
`define REG_STATUS 8'h0C
`define CTRL_RESET 32'h0000_0400
`define MASK_RESET 32'h0000_0000
`define CTRL_CURRENT_LIMIT_MODE_EN 0
`define CTRL_BUS_EN 1
`define CTRL_CONN_REQ 2
`define CTRL_AUTO_CHG 3
`define CTRL_RETRY_LSB 8
`define F_THERM 0
`define F_CC_OV 1
`define F_DATA_LINE_OV_FLAG 2
`define F_USB_OV 3
`define F_USB_UV 4
`define F_ILIM 5
`define F_BUS_OC 6
`define F_BUS_OV 7
`define F_BUS_UV 8
`define F_BUS_STG 9
`define F_CONN_OCL 10
`define F_CONN_OC 11
`define F_INPUT_UV_FLAG 12
`define F_SHIELD 13
`define F_RUNAWAY 14
`define F_REG_MODE 15
`define F_SUMMARY 16
`define F_VENDOR 17
`define MASK_VENDOR 0
`define MASK_SUMMARY 1
`endif

// file: shared/fault_pkg.sv
// Types shared by the port fault manager
package fault_pkg;
    typedef enum logic [1:0] {
        TERM_OPEN = 2'b00,
        TERM_RA = 2'b01,
        TERM_RD = 2'b10
    } term_t;
    typedef struct packed {
        logic over_temp;
        logic input_uv_flag;
        logic cc_a_ov;
        logic cc_b_ov;
        logic dp_ov;
        logic dm_ov;
        logic usb_ov;
        logic usb_uv;
        logic bus_ilim;
        logic bus_ocp;
        logic bus_ov;
        logic bus_uv;
        logic bus_below_2v0;
        logic bus_below_2v85;
        logic bus_runaway;
        logic bus_softstart;
        logic bus_transition;
        logic conn_oc_lo;
        logic conn_oc_hi;
        logic cc_below_stg;
        logic shield_thr;
        logic shield_slope;
        logic load_above_hi;
        logic load_below_lo;
        logic bc_started;
        logic pd_sent;
    } cmp_in_t;
    typedef struct packed {
        logic supply_lockout;
        logic high_voltage_enable;
        logic bus_sourced;
        term_t conn_config_line_a;
        term_t conn_config_line_b;
    } port_in_t;
    typedef struct packed {
        logic conv_en;
        logic conv_discharge;
        logic data_sw_close;
        logic cc_sw_close;
        logic cc_discharge;
        logic conn_sw_close;
        logic bc_reset;
        logic cur_regulate;
    } ctl_out_t;
endpackage

// file: verification/alert_host_model.sv
// Host side of the open-drain alert line with its pull-up
`timescale 1ns/100ps
module alert_host_model (
    input wire logic alert_oe_n,
    input wire logic alert_out,
    output logic alert_in
);
    // Released line floats to the pull-up level
    assign alert_in = alert_oe_n ? 1'b1 : alert_out;
endmodule

// file: verification/usb_port_fault_manager_tb_top.sv
// Self-checking bench for the port fault manager
`timescale 1ns/100ps
`include "fault_map.svh"
module usb_port_fault_manager_tb_top;
    import fault_pkg::*;
    localparam int MS = 20;
    localparam int TH = 40;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rd_s, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, gate, aout, aoe_n, ain, rdy_s;
    cmp_in_t cmp;
    port_in_t pin;
    ctl_out_t ctl;
    int failures = 0;
    int checks_done = 0;
    int bc_pulses = 0;
    usb_port_fault_manager #(.CYC_THERM(TH), .CYC_INUV(TH), .CYC_ILIM(100), .CYC_OCP(30),
        .CYC_OV_CL(60), .CYC_BUSUV(100), .CYC_CONN_OCL(50), .CYC_CONN_STG(150),
        .CYC_STG_DB(10), .CYC_RUNAWAY(30), .CYC_MS(MS)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp),
        .port_in(pin), .ctl_out(ctl), .shield_gate_out(gate), .alert_in(ain),
        .alert_out(aout), .alert_oe_n(aoe_n));
    alert_host_model u_host (.alert_oe_n(aoe_n), .alert_out(aout), .alert_in(ain));
    initial begin
        hclk = 0;
        forever #2 hclk = ~hclk;
    end
    // Mid-cycle copies keep edge sampling free of races
    always @(negedge hclk) begin
        rd_s = hrdata;
        rdy_s = hreadyout;
        if (ctl.bc_reset === 1'b1) bc_pulses++;
    end
    task stop_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (rdy_s !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 0;
        hwdata <= d;
        @(posedge hclk);
        while (rdy_s !== 1'b1) @(posedge hclk);
        q = rd_s;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task t_reset;
        bus(0, `REG_CTRL, 0);
        chk("ctrl", `CTRL_RESET, q);
        bus(0, `REG_MASK, 0);
        chk("mask", `MASK_RESET, q);
        bus(0, 32'h0000_0010, 0);
        chk("unmapped", 0, q);
        chk("hresp", 0, hresp);
        bus(1, `REG_MASK, 32'h0000_0003);
    endtask
    task t_gate;
        chk("gate open", 0, gate);
        pin.conn_config_line_a <= TERM_RD;
        cyc(4);
        chk("gate attach", 1, gate);
        pin.supply_lockout <= 1;
        cyc(4);
        chk("gate lockout", 0, gate);
        pin.supply_lockout <= 0;
        pin.high_voltage_enable <= 0;
        cyc(4);
        chk("gate hve", 0, gate);
        pin.high_voltage_enable <= 1;
        cyc(4);
    endtask
    task t_shield;
        int i;
        cmp.load_above_hi <= 1;
        cyc(1);
        cmp.load_above_hi <= 0;
        cmp.shield_thr <= 1;
        cyc(1300);
        cmp.shield_thr <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("suppressed", 0, q[`F_SHIELD]);
        cmp.load_below_lo <= 1;
        cyc(1);
        cmp.load_below_lo <= 0;
        cmp.shield_thr <= 1;
        cyc(`CYC_US(`T_SHLD_THR_US) + 20);
        chk("gate trip", 0, gate);
        cmp.shield_thr <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("shield flag", 1, q[`F_SHIELD]);
        chk("data sw", 0, ctl.data_sw_close);
        bus(1, `REG_FLAGS, 32'hFFFF_FFFF);
        cyc(MS / 2);
        chk("gate hold", 0, gate);
        i = 0;
        while (gate !== 1'b1 && i < MS + 200) begin
            cyc(1);
            i++;
        end
        chk("gate back", 1, gate);
    endtask
    task t_usb_ov;
        cmp.usb_ov <= 1;
        cyc(1);
        cmp.usb_ov <= 0;
        cyc(3);
        bus(0, `REG_FLAGS, 0);
        chk("usb ov", 1, q[`F_USB_OV]);
        chk("summary", 1, q[`F_SUMMARY]);
        chk("alert pin", 0, ain);
        chk("conv", 0, ctl.conv_en);
        bus(1, `REG_MASK, 32'h0000_0002);
        cyc(2);
        chk("alert masked", 1, ain);
        bus(1, `REG_FLAGS, 32'hFFFF_FFFF);
        bus(1, `REG_MASK, 32'h0000_0003);
    endtask
    task t_debounce;
        cmp.over_temp <= 1;
        cyc(TH - 5);
        cmp.over_temp <= 0;
        cyc(1);
        cmp.over_temp <= 1;
        cyc(TH - 5);
        cmp.over_temp <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("therm short", 0, q[`F_THERM]);
        cmp.over_temp <= 1;
        cyc(TH + 4);
        cmp.over_temp <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("therm", 1, q[`F_THERM]);
        bus(1, `REG_FLAGS, 32'hFFFF_FFFF);
    endtask
    task t_uv_gating;
        cyc(8 * MS);
        cmp.usb_uv <= 1;
        cmp.bus_ocp <= 1;
        cyc(60);
        cmp.usb_uv <= 0;
        cmp.bus_ocp <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("usb uv", 1, q[`F_USB_UV]);
        chk("ocp idle bus", 0, q[`F_BUS_OC]);
        chk("data sw kept", 1, ctl.data_sw_close);
    endtask
    task t_bus_faults;
        int n;
        n = bc_pulses;
        bus(1, `REG_CTRL, 32'h0000_0406);
        pin.bus_sourced <= 1;
        cyc(3);
        chk("conv on", 1, ctl.conv_en);
        chk("conn sw on", 1, ctl.conn_sw_close);
        cmp.bus_below_2v0 <= 1;
        cyc(1);
        cmp.bus_below_2v0 <= 0;
        cyc(3);
        chk("conv off", 0, ctl.conv_en);
        chk("discharge", 1, ctl.conv_discharge & ctl.cc_discharge);
        chk("cc sw open", 0, ctl.cc_sw_close);
        chk("conn sw open", 0, ctl.conn_sw_close);
        chk("bc reset", n + 1, bc_pulses);
        bus(0, `REG_CTRL, 0);
        chk("bus en", 0, q[`CTRL_BUS_EN]);
        bus(0, `REG_FLAGS, 0);
        chk("stg flag", 1, q[`F_BUS_STG]);
        bus(1, `REG_CTRL, 32'h0000_0401);
        cmp.bus_ilim <= 1;
        cyc(3);
        chk("regulate", 1, ctl.cur_regulate);
        bus(0, `REG_FLAGS, 0);
        chk("reg flag", 1, q[`F_REG_MODE]);
        chk("ilim fault", 0, q[`F_ILIM]);
        cmp.bus_ilim <= 0;
        cmp.pd_sent <= 1;
        cyc(1);
        cmp.pd_sent <= 0;
        cmp.shield_slope <= 1;
        cyc(`CYC_US(`T_SHLD_SLOPE_US) + 20);
        cmp.shield_slope <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("slope suppressed", 0, q[`F_SHIELD]);
        bus(0, `REG_STATUS, 0);
        chk("pd latch set", 1, q[4]);
        pin.bus_sourced <= 0;
        cyc(2);
        bus(0, `REG_STATUS, 0);
        chk("pd latch clear", 0, q[4]);
        cmp.input_uv_flag <= 1;
        cmp.cc_a_ov <= 1;
        cyc(TH + 4);
        cmp.input_uv_flag <= 0;
        cmp.cc_a_ov <= 0;
        bus(0, `REG_FLAGS, 0);
        chk("input_uv_flag", 1, q[`F_INPUT_UV_FLAG]);
        chk("cc ov", 1, q[`F_CC_OV]);
        bus(1, `REG_FLAGS, 32'hFFFF_FFFF);
    endtask
    initial begin
        hresetn = 0;
        hsel = 0;
        haddr = 0;
        htrans = 0;
        hwrite = 0;
        hsize = 3'h2;
        hwdata = 0;
        cmp = '0;
        pin = '0;
        pin.high_voltage_enable = 1;
        cyc(10);
        hresetn <= 1;
        cyc(1);
        t_reset;
        t_gate;
        t_shield;
        t_usb_ov;
        t_debounce;
        t_uv_gating;
        t_bus_faults;
        stop_test;
    end
    // Whole sequence needs well under 20000 cycles
    initial begin
        #80000;
        failures++;
        stop_test;
    end
endmodule
